/* vts_pkg.sv */
// Package: register map, field layout, reset values and states of the scheduler
package vts_pkg;

	localparam int NCH    = 14;
	localparam int CHW    = 4;
	localparam int ADDR_W = 8;
	localparam int IDX_W  = ADDR_W - 2;

	// Register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_TX_CONTROL = 6'h01;
	localparam logic [IDX_W-1:0] IDX_COMMAND    = 6'h03;
	localparam logic [IDX_W-1:0] IDX_LINE_STATE = 6'h04;
	localparam logic [IDX_W-1:0] IDX_TX_PROGRESS = 6'h05;
	localparam logic [IDX_W-1:0] IDX_LAST_FAIL  = 6'h07;
	localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS  = 6'h09;
	localparam logic [IDX_W-1:0] IDX_CHAN_BASE  = 6'h10;

	// Command fields
	localparam int CMD_IDLE  = 0;
	localparam int CMD_ACT   = 1;
	localparam int CMD_SLEEP = 2;
	localparam int CMD_REARB = 3;

	// Transmit control fields
	localparam int MR_LSB = 0;
	localparam int MR_W   = 4;

	// Channel word fields
	localparam int CH_SENT    = 0;
	localparam int CH_ABORT   = 1;
	localparam int CH_PROD    = 2;
	localparam int CH_RECV    = 3;
	localparam int CH_LEN_LSB = 4;
	localparam int LEN_W      = 5;
	localparam int CH_PTR_LSB = 9;
	localparam int PTR_W      = 7;

	// Status fields
	localparam int LS_IDLE    = 0;
	localparam int LS_ACTIVE  = 1;
	localparam int LS_SLEEP   = 2;
	localparam int LS_ATTEMPT = 3;
	localparam int PROG_CH_LSB = 4;
	localparam int IRQ_EXH  = 0;
	localparam int IRQ_TXOK = 1;
	localparam int IRQ_RXOK = 2;

	// Reset values
	localparam logic [7:0]  CMD_RST = 8'h01;
	localparam logic [7:0]  TXC_RST = 8'h00;
	localparam logic [15:0] CH_RST  = 16'h0009;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_ACTIVE  = 4'h2,
		ST_ATTEMPT = 4'h4,
		ST_SLEEP   = 4'h8
	} vts_state_t;

endpackage

/* vts_pick_if.sv */
// Interface: request vectors and lowest-index winners between scheduler and picker
`timescale 1ns/1ns
`default_nettype none
interface vts_pick_if #(parameter int N = vts_pkg::NCH);
	logic [N-1:0]             tx_req;
	logic [N-1:0]             rx_req;
	logic                     tx_hit;
	logic                     rx_hit;
	logic [vts_pkg::CHW-1:0]  tx_idx;
	logic [vts_pkg::CHW-1:0]  rx_idx;
	modport picker (input tx_req, input rx_req,
		output tx_hit, output rx_hit, output tx_idx, output rx_idx);
	modport user (output tx_req, output rx_req,
		input tx_hit, input rx_hit, input tx_idx, input rx_idx);
endinterface
`default_nettype wire

/* vts_pick.sv */
// Lowest-numbered channel picker for transmit and receive requests
`timescale 1ns/1ns
`default_nettype none
module vts_pick #(parameter int N = vts_pkg::NCH) (
	vts_pick_if.picker pk
);
	always_comb begin
		pk.tx_hit = 1'b0;
		pk.rx_hit = 1'b0;
		pk.tx_idx = '0;
		pk.rx_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pk.tx_req[i]) begin
				pk.tx_hit = 1'b1;
				pk.tx_idx = vts_pkg::CHW'(i);
			end
			if (pk.rx_req[i]) begin
				pk.rx_hit = 1'b1;
				pk.rx_idx = vts_pkg::CHW'(i);
			end
		end
	end
endmodule // vts_pick
`default_nettype wire

/* vts_sched.sv */
// Channel transmit scheduler, retry, abort, mode control and register file
// Functional notes
// - Frame matching several channels goes to the lowest-numbered armed one.
// - A channel that received becomes inactive; next match goes higher.
// - Lowest-numbered ready channel transmits first.
// - Retry, rearbitrate and abort act only on producer channels.
// - Enabling loads 4-bit retry counter; failures count down; zero flags, stops.
// - Setting N gives N retries, N plus one attempts.
// - Progress register shows retries done and current channel.
// - Only code, ack and CRC faults fail; latest cause kept in flags.
// - Lost contention never decrements; attempts repeat without limit.
// - One shared counter, loaded from latest written maximum retries.
// - Rearbitrate after current attempt serves lower-numbered channel, then resumes postponed one.
// - Idle after rearbitrate waits until transmit attempts have ended.
// - Disabled current channel: finish attempt, pass on or stop.
// - Abort flag cancels a channel not in attempt and sets sent on the same clock edge.
// - Reset leaves device idle, clock running, bus silent.
// - Bus transmit output undriven while idle.
// - Line state register shows the idle state.
// - Sleep bit wins, stops oscillator at once, registers stay reachable.
// - Setting idle or activate leaves sleep.
// - Zero length means linked; pointer names channel owning the area.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module vts_sched #(parameter int NCH = vts_pkg::NCH) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [vts_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [vts_pkg::ADDR_W-1:0]  araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	output logic                             attempt_start,
	output logic [vts_pkg::CHW-1:0]          tx_chan,
	output logic [vts_pkg::PTR_W-1:0]        tx_area_ptr,
	output logic [vts_pkg::LEN_W-1:0]        tx_area_len,
	input  wire logic                        attempt_done,
	input  wire logic                        fail_code_viol,
	input  wire logic                        fail_ack,
	input  wire logic                        fail_crc,
	input  wire logic                        lost_contention,
	input  wire logic                        rx_frame,
	input  wire logic [NCH-1:0]              rx_match,
	output logic                             rx_deliver,
	output logic [vts_pkg::CHW-1:0]          rx_chan,
	output logic [vts_pkg::PTR_W-1:0]        rx_area_ptr,
	output logic [vts_pkg::LEN_W-1:0]        rx_area_len,
	input  wire logic                        line_tx_bit,
	output logic                             txd_o,
	output logic                             txd_oe,
	output logic                             osc_run
);
	localparam int CHW = vts_pkg::CHW;
	localparam int IW  = vts_pkg::IDX_W;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic                awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]          bresp_r, rresp_r;
	logic [31:0]         rdata_r;
	logic [7:0]          txc_r, cmd_r;
	logic                rearb_pend_r;
	logic [15:0]         ch_r [NCH];
	vts_pkg::vts_state_t state_r, state_nxt;
	logic [CHW-1:0]      cur_r, post_r, sel_idx;
	logic                have_cur_r, post_valid_r;
	logic [3:0]          cnt_r, load_r, done_cnt_r;
	logic [2:0]          fail_r, irq_r;
	logic                attempt_start_r, rx_deliver_r, txd_o_r, txd_oe_r;
	logic                osc_run_r;
	logic [CHW-1:0]      tx_chan_r, rx_chan_r;
	logic [6:0]          tx_ptr_r, rx_ptr_r;
	logic [4:0]          tx_len_r, rx_len_r;
	logic [NCH-1:0]      tx_ready, abort_apply, rx_armed, sent_set, recv_set;
	logic [IW-1:0]       widx, ridx;
	logic                wr_fire, rd_fire, wr_lo, wr_hi;
	logic                want_active, attempting, live;
	logic                cont, resume, sel_ok, start, preempt;
	logic                done_fire, any_fail, success, exhausted, rx_fire;
	logic [3:0]          mr;

	vts_pick_if #(.N(NCH)) pk ();
	vts_pick #(.N(NCH)) u_pick (.pk(pk.picker));

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [11:0] area_of(input logic [CHW-1:0] c);
		logic [15:0]    w;
		logic [15:0]    t;
		logic [CHW-1:0] link;
		w    = ch_r[c];
		link = w[vts_pkg::CH_PTR_LSB +: CHW];
		t    = (32'(link) < NCH) ? ch_r[link] : w;
		if (w[vts_pkg::CH_LEN_LSB +: vts_pkg::LEN_W] == 5'h00) begin
			area_of = {t[vts_pkg::CH_PTR_LSB +: vts_pkg::PTR_W],
				t[vts_pkg::CH_LEN_LSB +: vts_pkg::LEN_W]};
		end else begin
			area_of = {w[vts_pkg::CH_PTR_LSB +: vts_pkg::PTR_W],
				w[vts_pkg::CH_LEN_LSB +: vts_pkg::LEN_W]};
		end
	endfunction

	function automatic logic is_mapped(input logic [IW-1:0] i);
		is_mapped = (i == vts_pkg::IDX_TX_CONTROL) || (i == vts_pkg::IDX_COMMAND)
			|| (i == vts_pkg::IDX_LINE_STATE) || (i == vts_pkg::IDX_TX_PROGRESS)
			|| (i == vts_pkg::IDX_LAST_FAIL) || (i == vts_pkg::IDX_IRQ_FLAGS)
			|| ((i >= vts_pkg::IDX_CHAN_BASE)
			&& (i < IW'(32'(vts_pkg::IDX_CHAN_BASE) + NCH)));
	endfunction

	function automatic logic [NCH-1:0] low_mask(input logic [CHW-1:0] c);
		low_mask = NCH'((1 << c) - 1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Per-channel status terms
	assign attempting = (state_r == vts_pkg::ST_ATTEMPT);
	assign live       = (state_r == vts_pkg::ST_ACTIVE) || attempting;
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			assign tx_ready[i] = ch_r[i][vts_pkg::CH_PROD]
				& ~ch_r[i][vts_pkg::CH_SENT] & ~ch_r[i][vts_pkg::CH_ABORT];
			assign abort_apply[i] = ch_r[i][vts_pkg::CH_ABORT]
				& ch_r[i][vts_pkg::CH_PROD] & ~ch_r[i][vts_pkg::CH_SENT]
				& ~(attempting & (cur_r == CHW'(i)));
			assign rx_armed[i] = ~ch_r[i][vts_pkg::CH_RECV];
			assign sent_set[i] = abort_apply[i] | (done_fire
				& (success | exhausted) & (cur_r == CHW'(i)));
			assign recv_set[i] = rx_fire & (pk.rx_idx == CHW'(i));
		end
	endgenerate

	assign pk.tx_req = tx_ready;
	assign pk.rx_req = rx_match & rx_armed & {NCH{live}};
	assign rx_fire   = rx_frame & pk.rx_hit;

	////////////////////////////////////////////////////////////////////////
	// Channel choice and attempt outcome
	assign mr          = txc_r[vts_pkg::MR_LSB +: vts_pkg::MR_W];
	assign want_active = cmd_r[vts_pkg::CMD_ACT] & ~cmd_r[vts_pkg::CMD_IDLE];
	assign cont    = have_cur_r & tx_ready[cur_r]
		& ~(rearb_pend_r & pk.tx_hit & (pk.tx_idx != cur_r));
	assign resume  = ~cont & post_valid_r & tx_ready[post_r];
	assign sel_idx = cont ? cur_r : (resume ? post_r : pk.tx_idx);
	assign sel_ok  = cont | resume | pk.tx_hit;
	assign start   = (state_r == vts_pkg::ST_ACTIVE) & want_active
		& ~cmd_r[vts_pkg::CMD_SLEEP] & sel_ok;
	assign preempt = start & have_cur_r & tx_ready[cur_r] & ~cont;
	assign done_fire = attempting & attempt_done;
	assign any_fail  = fail_code_viol | fail_ack | fail_crc;
	assign success   = ~any_fail & ~lost_contention;
	assign exhausted = any_fail & (cnt_r == 4'h0);

	always_comb begin
		state_nxt = state_r;
		if (cmd_r[vts_pkg::CMD_SLEEP]) begin
			state_nxt = vts_pkg::ST_SLEEP;
		end else begin
			unique case (state_r)
				vts_pkg::ST_SLEEP: state_nxt = vts_pkg::ST_IDLE;
				vts_pkg::ST_IDLE: if (want_active) begin
					state_nxt = vts_pkg::ST_ACTIVE;
				end
				vts_pkg::ST_ACTIVE: if (!want_active) begin
					state_nxt = vts_pkg::ST_IDLE;
				end else if (start) begin
					state_nxt = vts_pkg::ST_ATTEMPT;
				end
				vts_pkg::ST_ATTEMPT: if (attempt_done) begin
					state_nxt = vts_pkg::ST_ACTIVE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= vts_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	assign widx    = awaddr[vts_pkg::ADDR_W-1:2];
	assign ridx    = araddr[vts_pkg::ADDR_W-1:2];
	assign wr_fire = awready_r & awvalid & wvalid;
	assign rd_fire = arready_r & arvalid;
	assign wr_lo   = wr_fire & wstrb[0];
	assign wr_hi   = wr_fire & wstrb[1];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= vts_pkg::RESP_OKAY;
		end else begin
			awready_r <= awvalid & wvalid & ~awready_r & ~bvalid_r;
			wready_r  <= awvalid & wvalid & ~awready_r & ~bvalid_r;
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r  <= is_mapped(widx) ? vts_pkg::RESP_OKAY
					: vts_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= vts_pkg::RESP_OKAY;
			rdata_r   <= 32'h00000000;
		end else begin
			arready_r <= arvalid & ~arready_r & ~rvalid_r;
			if (rd_fire) begin
				rvalid_r <= 1'b1;
				rresp_r  <= is_mapped(ridx) ? vts_pkg::RESP_OKAY
					: vts_pkg::RESP_SLVERR;
				rdata_r  <= 32'h00000000;
				if (ridx == vts_pkg::IDX_TX_CONTROL) begin
					rdata_r[7:0] <= txc_r;
				end
				if (ridx == vts_pkg::IDX_COMMAND) begin
					rdata_r[7:0] <= cmd_r;
					rdata_r[vts_pkg::CMD_REARB] <= rearb_pend_r;
				end
				if (ridx == vts_pkg::IDX_LINE_STATE) begin
					rdata_r[vts_pkg::LS_IDLE]    <= (state_r == vts_pkg::ST_IDLE);
					rdata_r[vts_pkg::LS_ACTIVE]  <= live;
					rdata_r[vts_pkg::LS_SLEEP]   <= (state_r == vts_pkg::ST_SLEEP);
					rdata_r[vts_pkg::LS_ATTEMPT] <= attempting;
				end
				if (ridx == vts_pkg::IDX_TX_PROGRESS) begin
					rdata_r[7:0] <= {cur_r, done_cnt_r};
				end
				if (ridx == vts_pkg::IDX_LAST_FAIL) begin
					rdata_r[2:0] <= fail_r;
				end
				if (ridx == vts_pkg::IDX_IRQ_FLAGS) begin
					rdata_r[2:0] <= irq_r;
				end
				for (int i = 0; i < NCH; i++) begin
					if (ridx == IW'(32'(vts_pkg::IDX_CHAN_BASE) + i)) begin
						rdata_r[15:0] <= ch_r[i];
					end
				end
			end else if (rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txc_r <= vts_pkg::TXC_RST;
		end else if (wr_lo && widx == vts_pkg::IDX_TX_CONTROL) begin
			txc_r <= wdata[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_r <= vts_pkg::CMD_RST;
		end else if (wr_lo && widx == vts_pkg::IDX_COMMAND) begin
			cmd_r[vts_pkg::CMD_IDLE] <= wdata[vts_pkg::CMD_IDLE];
			cmd_r[vts_pkg::CMD_ACT]  <= wdata[vts_pkg::CMD_ACT];
			if (wdata[vts_pkg::CMD_SLEEP]) begin
				cmd_r[vts_pkg::CMD_SLEEP] <= 1'b1;
			end else if (wdata[vts_pkg::CMD_IDLE] | wdata[vts_pkg::CMD_ACT]) begin
				cmd_r[vts_pkg::CMD_SLEEP] <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rearb_pend_r <= 1'b0;
		end else if (wr_lo && widx == vts_pkg::IDX_COMMAND
				&& wdata[vts_pkg::CMD_REARB]) begin
			rearb_pend_r <= 1'b1;
		end else if (start) begin
			rearb_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!aresetn) begin
				ch_r[i] <= vts_pkg::CH_RST;
			end else begin
				if (wr_lo && widx == IW'(32'(vts_pkg::IDX_CHAN_BASE) + i)) begin
					ch_r[i][7:0] <= wdata[7:0];
				end
				if (wr_hi && widx == IW'(32'(vts_pkg::IDX_CHAN_BASE) + i)) begin
					ch_r[i][15:8] <= wdata[15:8];
				end
				if (abort_apply[i]) begin
					ch_r[i][vts_pkg::CH_ABORT] <= 1'b0;
				end
				if (sent_set[i]) begin
					ch_r[i][vts_pkg::CH_SENT] <= 1'b1;
				end
				if (recv_set[i]) begin
					ch_r[i][vts_pkg::CH_RECV] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Scheduling and retry counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_r        <= '0;
			have_cur_r   <= 1'b0;
			post_r       <= '0;
			post_valid_r <= 1'b0;
			cnt_r        <= 4'h0;
			load_r       <= 4'h0;
			done_cnt_r   <= 4'h0;
		end else if (start) begin
			cur_r      <= sel_idx;
			have_cur_r <= 1'b1;
			if (!cont) begin
				cnt_r      <= mr;
				load_r     <= mr;
				done_cnt_r <= 4'h0;
			end
			if (preempt) begin
				post_r       <= cur_r;
				post_valid_r <= 1'b1;
			end else if (resume || (post_valid_r && !tx_ready[post_r])) begin
				post_valid_r <= 1'b0;
			end
		end else if (done_fire) begin
			if (success || exhausted) begin
				have_cur_r <= 1'b0;
			end else if (any_fail) begin
				cnt_r      <= cnt_r - 4'h1;
				done_cnt_r <= done_cnt_r + 4'h1;
			end
		end else if (state_r == vts_pkg::ST_ACTIVE && have_cur_r
				&& !tx_ready[cur_r]) begin
			have_cur_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_r <= 3'h0;
		end else if (done_fire && any_fail) begin
			fail_r <= {fail_crc, fail_ack, fail_code_viol};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_r <= 3'h0;
		end else begin
			irq_r <= (irq_r & ~((wr_lo && widx == vts_pkg::IDX_IRQ_FLAGS)
				? wdata[2:0] : 3'h0))
				| {rx_fire, done_fire & success, done_fire & exhausted};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link-side outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			attempt_start_r <= 1'b0;
			tx_chan_r       <= '0;
			tx_ptr_r        <= 7'h00;
			tx_len_r        <= 5'h00;
		end else begin
			attempt_start_r <= start;
			if (start) begin
				tx_chan_r            <= sel_idx;
				{tx_ptr_r, tx_len_r} <= area_of(sel_idx);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_deliver_r <= 1'b0;
			rx_chan_r    <= '0;
			rx_ptr_r     <= 7'h00;
			rx_len_r     <= 5'h00;
		end else begin
			rx_deliver_r <= rx_fire;
			if (rx_fire) begin
				rx_chan_r            <= pk.rx_idx;
				{rx_ptr_r, rx_len_r} <= area_of(pk.rx_idx);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txd_o_r   <= 1'b1;
			txd_oe_r  <= 1'b0;
			osc_run_r <= 1'b1;
		end else begin
			txd_o_r   <= line_tx_bit;
			txd_oe_r  <= (state_nxt == vts_pkg::ST_ACTIVE)
				|| (state_nxt == vts_pkg::ST_ATTEMPT);
			osc_run_r <= ~cmd_r[vts_pkg::CMD_SLEEP];
		end
	end

	assign awready = awready_r;
	assign wready  = wready_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = rdata_r;
	assign attempt_start = attempt_start_r;
	assign tx_chan     = tx_chan_r;
	assign tx_area_ptr = tx_ptr_r;
	assign tx_area_len = tx_len_r;
	assign rx_deliver  = rx_deliver_r;
	assign rx_chan     = rx_chan_r;
	assign rx_area_ptr = rx_ptr_r;
	assign rx_area_len = rx_len_r;
	assign txd_o   = txd_o_r;
	assign txd_oe  = txd_oe_r;
	assign osc_run = osc_run_r;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	function automatic logic [NCH-1:0] sent_vec();
		for (int i = 0; i < NCH; i++) begin
			sent_vec[i] = ch_r[i][vts_pkg::CH_SENT];
		end
	endfunction

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_rx_lowest_wins: assert property (rx_deliver_r |->
		(($past(pk.rx_req) & low_mask(rx_chan_r)) == '0))
		else $error("receive not given to lowest channel");
	a_rx_goes_inactive: assert property (rx_deliver_r |->
		ch_r[rx_chan_r][vts_pkg::CH_RECV])
		else $error("receiving channel still armed");
	a_tx_lowest_first: assert property (attempt_start_r |->
		$past(cont) || $past(resume)
		|| (($past(tx_ready) & low_mask(tx_chan_r)) == '0))
		else $error("transmit not lowest ready channel");
	a_tx_producer_only: assert property (start |->
		ch_r[sel_idx][vts_pkg::CH_PROD])
		else $error("non producer channel started");
	a_retry_load_mr: assert property (start && !cont |=>
		cnt_r == $past(mr) && done_cnt_r == 4'h0)
		else $error("retry counter not loaded");
	a_retry_sum_ok: assert property (attempting |->
		(4'(cnt_r + done_cnt_r) == load_r))
		else $error("retry count out of step");
	a_exhaust_flag: assert property (done_fire && exhausted |=>
		irq_r[vts_pkg::IRQ_EXH] && !have_cur_r)
		else $error("exhaustion not flagged");
	a_contention_free: assert property (done_fire && !any_fail |=>
		$stable(cnt_r))
		else $error("retry counter changed without failure");
	a_idle_waits_end: assert property (attempting && !attempt_done
		&& !cmd_r[vts_pkg::CMD_SLEEP] |=> attempting)
		else $error("attempt left before its end");
	a_idle_txd_off: assert property ((state_r == vts_pkg::ST_IDLE)
		&& !want_active |=> !txd_oe_r)
		else $error("bus driven while idle");
	a_sleep_osc_off: assert property (cmd_r[vts_pkg::CMD_SLEEP] |=>
		!osc_run_r ##0 (state_r == vts_pkg::ST_SLEEP))
		else $error("sleep did not stop oscillator");
	a_abort_sets_sent: assert property ((|abort_apply) |=>
		((sent_vec() & $past(abort_apply)) == $past(abort_apply)))
		else $error("abort did not set sent");

endmodule // vts_sched
`default_nettype wire

/* vts_eng_model.sv */
// Frame engine model: answers each attempt after a variable delay
`timescale 1ns/1ns
`default_nettype none
module vts_eng_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       attempt_start,
	input  wire logic [3:0] fail_sel,
	input  wire logic [3:0] dly,
	output logic            attempt_done,
	output logic [3:0]      quals,
	output logic            line_tx_bit
);
	logic       busy_r;
	logic [3:0] cnt_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
			attempt_done <= 1'b0;
		end else begin
			attempt_done <= 1'b0;
			if (attempt_start) begin
				busy_r <= 1'b1;
				cnt_r <= dly;
			end else if (busy_r && cnt_r == 4'h0) begin
				busy_r <= 1'b0;
				attempt_done <= 1'b1;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
	// Qualifiers mean nothing outside done, so show junk there
	assign quals = attempt_done ? fail_sel : ~fail_sel;
	assign line_tx_bit = busy_r ? cnt_r[0] : 1'b1;
endmodule // vts_eng_model
`default_nettype wire

/* testbench.sv */
// Testbench: register access, transmit order, retries, receive, modes
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        aclk = 1'b0, aresetn = 1'b0, rx_frame = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rnd = 32'h1F51;
	logic [13:0] rx_match = 14'h0, armed, m;
	logic [3:0]  fail_sel = 4'h0, dmin = 4'h0, q, tx_chan, rx_chan;
	logic [6:0]  tx_ptr, rx_ptr;
	logic [4:0]  tx_len, rx_len;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, st, done;
	logic        tx_bit, txd_o, txd_oe, osc_run, rx_deliver;
	logic        tx_bit_q = 1'b1;
	logic [33:0] exp_rd[$];
	logic [15:0] exp_ch[$], exp_rx[$];
	int          n_errors = 0, checks = 0, cyc = 0, e;
	always #4 aclk = ~aclk;
	vts_sched u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.attempt_start(st), .tx_chan, .tx_area_ptr(tx_ptr),
		.tx_area_len(tx_len),
		.attempt_done(done), .fail_code_viol(q[3]), .fail_ack(q[2]),
		.fail_crc(q[1]), .lost_contention(q[0]), .rx_frame, .rx_match,
		.rx_deliver, .rx_chan, .rx_area_ptr(rx_ptr),
		.rx_area_len(rx_len),
		.line_tx_bit(tx_bit), .txd_o, .txd_oe, .osc_run);
	vts_eng_model u_eng (.aclk, .aresetn, .attempt_start(st), .fail_sel,
		.dly(rnd[3:0] | dmin), .attempt_done(done), .quals(q),
		.line_tx_bit(tx_bit));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input bit ok);
		checks++;
		if (!ok) begin
			n_errors++;
			$display("Error at %0t: mismatch", $time);
		end
	endtask
	task end_sim;
		$display("Errors %0d, checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wr(input logic [5:0] i, input logic [15:0] d);
		awaddr <= {i, 2'b00};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [5:0] i, input logic [1:0] r, input logic [7:0] d);
		exp_rd.push_back({r, 24'h0, d});
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		rnd <= lfsr(rnd);
		if (rvalid === 1'b1 && rready === 1'b1)
			chk(exp_rd.size() > 0 && {rresp, rdata} === exp_rd.pop_front());
		if (st === 1'b1)
			chk(exp_ch.size() > 0
				&& {tx_ptr, tx_len, tx_chan} === exp_ch.pop_front());
		if (rx_deliver === 1'b1)
			chk(exp_rx.size() > 0
				&& {rx_ptr, rx_len, rx_chan} === exp_rx.pop_front());
		tx_bit_q <= tx_bit;
		if (aresetn === 1'b1)
			chk(txd_o === tx_bit_q);
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_sim;
		end
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(txd_oe === 1'b0 && osc_run === 1'b1);
		rd(vts_pkg::IDX_LINE_STATE, 2'h0, 8'h01);
		rd(6'h3F, vts_pkg::RESP_SLVERR, 8'h00);
		wr(vts_pkg::IDX_TX_CONTROL, 16'h0001);
		wr(vts_pkg::IDX_CHAN_BASE + 6'h08, 16'h0004);
		wr(vts_pkg::IDX_CHAN_BASE + 6'h05, 16'h0004);
		exp_ch = '{16'h0005, 16'h0005, 16'h0008,
			16'h0008};
		fail_sel <= 4'h4;
		wr(vts_pkg::IDX_COMMAND, 16'h0002);
		while (exp_ch.size() > 0) @(posedge aclk);
		repeat (24) @(posedge aclk);
		rd(vts_pkg::IDX_IRQ_FLAGS, 2'h0, 8'h01);
		rd(vts_pkg::IDX_LAST_FAIL, 2'h0, 8'h02);
		rd(vts_pkg::IDX_CHAN_BASE + 6'h05, 2'h0, 8'h05);
		for (int c = 0; c < 14; c++)
			wr(vts_pkg::IDX_CHAN_BASE + 6'(c), 16'h0000);
		armed = 14'h3FFF;
		repeat (6) begin
			m = rnd[13:0] | 14'h0021;
			e = 15;
			for (int b = 13; b >= 0; b--)
				if (m[b] && armed[b]) e = b;
			if (e < 14) begin
				exp_rx.push_back(16'(e));
				armed[e] = 1'b0;
			end
			rx_match <= m;
			rx_frame <= 1'b1;
			@(posedge aclk);
			rx_frame <= 1'b0;
			repeat (3) @(posedge aclk);
		end
		dmin <= 4'hF;
		wr(vts_pkg::IDX_CHAN_BASE + 6'h0C, 16'h5460);
		exp_ch = '{16'h0008, 16'h5465, 16'h5465, 16'h0008,
			16'h0008};
		wr(vts_pkg::IDX_CHAN_BASE + 6'h08, 16'h0004);
		while (exp_ch.size() > 4) @(posedge aclk);
		wr(vts_pkg::IDX_CHAN_BASE + 6'h05, 16'h1804);
		wr(vts_pkg::IDX_COMMAND, 16'h000A);
		while (exp_ch.size() > 0) @(posedge aclk);
		repeat (24) @(posedge aclk);
		rd(vts_pkg::IDX_TX_PROGRESS, 2'h0, 8'h81);
		exp_ch = '{16'h0003, 16'h0003};
		fail_sel <= 4'h1;
		wr(vts_pkg::IDX_CHAN_BASE + 6'h03, 16'h0004);
		while (exp_ch.size() > 0) @(posedge aclk);
		fail_sel <= 4'h0;
		repeat (24) @(posedge aclk);
		rd(vts_pkg::IDX_TX_PROGRESS, 2'h0, 8'h30);
		rd(vts_pkg::IDX_IRQ_FLAGS, 2'h0, 8'h07);
		wr(vts_pkg::IDX_CHAN_BASE + 6'h07, 16'h0006);
		wr(vts_pkg::IDX_CHAN_BASE + 6'h06, 16'h0002);
		rd(vts_pkg::IDX_CHAN_BASE + 6'h07, 2'h0, 8'h05);
		rd(vts_pkg::IDX_CHAN_BASE + 6'h06, 2'h0, 8'h02);
		wr(vts_pkg::IDX_COMMAND, 16'h0004);
		repeat (2) @(posedge aclk);
		chk(osc_run === 1'b0 && txd_oe === 1'b0);
		rd(vts_pkg::IDX_LINE_STATE, 2'h0, 8'h04);
		wr(vts_pkg::IDX_COMMAND, 16'h0002);
		rd(vts_pkg::IDX_LINE_STATE, 2'h0, 8'h02);
		repeat (4) @(posedge aclk);
		chk(exp_rd.size() == 0 && exp_rx.size() == 0 && exp_ch.size() == 0
			&& txd_oe === 1'b1 && osc_run === 1'b1);
		end_sim;
	end
endmodule // testbench
`default_nettype wire
